// >>> logic/vfd_display_driver.sv
`timescale 1ns/1ps
module vfd_display_driver
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // data memory access from the core
  input  wire logic [7:0]  ADDR,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  input  wire logic        INDIRECT,
  input  wire logic [7:0]  WDATA,
  output logic      [7:0]  RDATA,
  output logic             RDATA_VALID,
  output logic             GPR_SEL,
  // configuration options and system state
  input  wire logic        OPT_RTC_SRC,
  input  wire logic [2:0]  OPT_DIV_SEL,
  input  wire logic        OPT_HALT_ON,
  input  wire logic        RTC_OSC,
  input  wire logic        HALT,
  // tube drive
  output logic      [10:0] GRID_LINES,
  output logic      [15:0] SEGMENT_LINES
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]  ctrl_q, ctrl_d;         // display_control
  logic [7:0]  bank_q, bank_d;         // ram_bank_select
  logic        in_range;               // address inside 40H..55H
  logic        dmem_hit;               // access really reaches display bytes
  logic        dmem_we;                // display byte write
  logic [4:0]  dmem_idx;               // byte index 0..21
  logic [7:0]  dmem_rdata;             // registered cpu read of the memory
  logic [1:0]  rsrc_q, rsrc_d;         // read source: 0 none,1 ctrl,2 bank,3 mem
  logic        rpend_q, rpend_d;       // read answered next cycle
  logic        gpr_q, gpr_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        tick;                   // driver clock tick
  logic        forced_off;             // halt turns the tube off unless on rtc source with the keep option
  disp_state_e disp_q, disp_d;
  logic [3:0]  phase_q, phase_d;       // sixteenth within the grid slot
  logic [3:0]  grid_q, grid_d;         // grid being scanned
  logic [3:0]  gridp_q, gridp_d;       // grid aligned with scan_word
  logic        litp_q, litp_d;         // pulse on, aligned with scan_word
  logic [15:0] scan_word;
  logic [10:0] grid_out_q, grid_out_d;
  logic [15:0] seg_out_q, seg_out_d;

  // ****************************************
  // core access decode
  // ****************************************
  // only the second indirect pointer in bank one lands in display memory
  always_comb begin
    in_range = (ADDR >= DMEM_FIRST) && (ADDR <= DMEM_LAST);
    dmem_hit = in_range && INDIRECT && (bank_q == DMEM_BANK);
    dmem_we  = WR_EN && dmem_hit;
    dmem_idx = 5'(ADDR - DMEM_FIRST);
  end

  // register writes; control bit 3 is never stored
  always_comb begin
    ctrl_d = ctrl_q;
    bank_d = bank_q;
    if (WR_EN && ADDR == CTRL_ADDR) begin
      ctrl_d = WDATA & CTRL_WMASK;
    end
    if (WR_EN && ADDR == BANK_PTR_ADDR) begin
      bank_d = WDATA;
    end
  end

  // read pipeline: source noted at the request, data muxed one edge later
  always_comb begin
    rsrc_d  = 2'h0;
    rpend_d = RD_EN && !WR_EN && (dmem_hit || ADDR == CTRL_ADDR || ADDR == BANK_PTR_ADDR);
    if (ADDR == CTRL_ADDR) begin
      rsrc_d = 2'h1;
    end else if (ADDR == BANK_PTR_ADDR) begin
      rsrc_d = 2'h2;
    end else if (dmem_hit) begin
      rsrc_d = 2'h3;
    end
    // in-range access that misses the display goes to general memory
    gpr_d    = (RD_EN || WR_EN) && in_range && !dmem_hit;
    rvalid_d = rpend_q;
    case (rsrc_q)
      2'h1:    rdata_d = ctrl_q;
      2'h2:    rdata_d = bank_q;
      2'h3:    rdata_d = dmem_rdata;
      default: rdata_d = 8'h00;
    endcase
    if (!rpend_q) begin
      rdata_d = rdata_q;
    end
  end

  // access registers
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ctrl_q   <= CTRL_RESET;
      bank_q   <= BANK_RESET;
      rsrc_q   <= 2'h0;
      rpend_q  <= 1'b0;
      gpr_q    <= 1'b0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      bank_q   <= bank_d;
      rsrc_q   <= rsrc_d;
      rpend_q  <= rpend_d;
      gpr_q    <= gpr_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // memory and driver clock
  // ****************************************
  vfd_dmem u_dmem (
    .clk       (MCLK),
    .cpu_we    (dmem_we),
    .cpu_idx   (dmem_idx),
    .cpu_wdata (WDATA),
    .cpu_rdata (dmem_rdata),
    .scan_grid (grid_q),
    .scan_word (scan_word)
  );

  vfd_tick u_tick (
    .clk     (MCLK),
    .rst_n   (NRST),
    .rtc_src (OPT_RTC_SRC),
    .div_sel (OPT_DIV_SEL),
    .rtc_osc (RTC_OSC),
    .tick    (tick)
  );

  // ****************************************
  // scan state
  // ****************************************
  // the system/4 source dies in halt, so the tube is turned off regardless
  always_comb begin
    forced_off = HALT && (!OPT_RTC_SRC || !OPT_HALT_ON);
    disp_d     = DISP_RUN;
    if (!ctrl_q[ENABLE_BIT]) begin
      disp_d = DISP_OFF;
    end else if (forced_off) begin
      disp_d = DISP_HALT;
    end
  end

  // slot walk: sixteen ticks per grid, wrap at the last active grid
  always_comb begin
    phase_d = phase_q;
    grid_d  = grid_q;
    unique case (disp_q)
      DISP_RUN: begin
        if (tick) begin
          phase_d = phase_q + 4'h1;
          if (phase_q == LAST_PHASE) begin
            // a shrunk arrangement may leave grid_q past the end
            if (grid_q + 4'h1 >= grid_count(ctrl_q[ARR_LSB +: 3])) begin
              grid_d = 4'h0;
            end else begin
              grid_d = grid_q + 4'h1;
            end
          end
        end
      end
      DISP_OFF, DISP_HALT: begin
        phase_d = 4'h0;
        grid_d  = 4'h0;
      end
    endcase
    // stage that lines up with the one-cycle memory read
    gridp_d = grid_q;
    litp_d  = (disp_q == DISP_RUN)
              && ({1'b0, phase_q} < dim_width(ctrl_q[DIM_LSB +: 3]));
  end

  // tube outputs: every update follows the stored bytes with no cpu action
  always_comb begin
    grid_out_d = 11'h000;
    seg_out_d  = 16'h0000;
    if (litp_q && disp_q == DISP_RUN) begin
      grid_out_d = 11'(12'h001 << gridp_q);
      seg_out_d  = scan_word & seg_mask(ctrl_q[ARR_LSB +: 3]);
    end
  end

  // scan registers; off and halt clear outputs, memory untouched
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      disp_q     <= DISP_OFF;
      phase_q    <= 4'h0;
      grid_q     <= 4'h0;
      gridp_q    <= 4'h0;
      litp_q     <= 1'b0;
      grid_out_q <= 11'h000;
      seg_out_q  <= 16'h0000;
    end else begin
      disp_q     <= disp_d;
      phase_q    <= phase_d;
      grid_q     <= grid_d;
      gridp_q    <= gridp_d;
      litp_q     <= litp_d;
      grid_out_q <= grid_out_d;
      seg_out_q  <= seg_out_d;
    end
  end

  assign RDATA         = rdata_q;
  assign RDATA_VALID   = rvalid_q;
  assign GPR_SEL       = gpr_q;
  assign GRID_LINES    = grid_out_q;
  assign SEGMENT_LINES = seg_out_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  ctrl_reset_a: assert property (disable iff (1'b0) !NRST |=> ctrl_q == CTRL_RESET)
    else $error("control register not at reset value");
  unused_bit_a: assert property ((RD_EN && !WR_EN && ADDR == CTRL_ADDR) |=> ##1
    (RDATA_VALID && !RDATA[UNUSED_BIT])) else $error("control bit 3 read back as one");
  bank_write_a: assert property ((WR_EN && ADDR == BANK_PTR_ADDR) |=>
    bank_q == $past(WDATA)) else $error("bank pointer not updated");
  gpr_route_a: assert property ((WR_EN && in_range && bank_q != DMEM_BANK) |=> GPR_SEL)
    else $error("range access not routed to general memory");
  // a direct access in the range is always handed to general memory
  direct_block_a: assert property ((in_range && !INDIRECT && (WR_EN || RD_EN)) |=>
    GPR_SEL) else $error("direct access reached display memory");
  drive_off_a: assert property (!ctrl_q[ENABLE_BIT] [*3] |->
    (GRID_LINES == 11'h000 && SEGMENT_LINES == 16'h0000)) else $error("lines driven while off");
  halt_off_a: assert property ((HALT && !OPT_RTC_SRC) [*3] |->
    GRID_LINES == 11'h000) else $error("grid driven in halt on system source");
  halt_opt_a: assert property ((HALT && !OPT_HALT_ON) [*3] |->
    SEGMENT_LINES == 16'h0000) else $error("segments driven in halt with option off");
  one_grid_a: assert property ($onehot0(GRID_LINES))
    else $error("more than one grid driven");
  seg_limit_a: assert property ($stable(ctrl_q) [*3] |->
    (SEGMENT_LINES & ~seg_mask(ctrl_q[ARR_LSB +: 3])) == 16'h0000)
    else $error("segment beyond arrangement driven");

  // no general memory strobe without an access inside the range
  gpr_quiet_a: assert property (!((WR_EN || RD_EN) && in_range) |=> !GPR_SEL)
    else $error("general memory strobe without a range access");
  // an indirect bank-one read of a display byte is always answered two edges on
  mem_read_a: assert property ((RD_EN && !WR_EN && dmem_hit) |=> ##1 RDATA_VALID)
    else $error("display byte read not answered");
  // enable alone is enough to scan while the core runs
  enable_run_a: assert property ((ctrl_q[ENABLE_BIT] && !HALT) |=> disp_q == DISP_RUN)
    else $error("scan not running while enabled");
  // rtc source with the keep option rides through halt
  halt_keep_a: assert property ((HALT && OPT_RTC_SRC && OPT_HALT_ON)
    && ctrl_q[ENABLE_BIT] |=> disp_q == DISP_RUN)
    else $error("scan stopped in halt with keep option");
  // while scanning, the slot phase only moves on a driver tick
  phase_hold_a: assert property ((disp_q == DISP_RUN && !tick) |=> $stable(phase_q))
    else $error("phase moved without a tick");
  // segments never light without a grid behind them
  seg_dark_a: assert property ((GRID_LINES == 11'h000) |-> SEGMENT_LINES == 16'h0000)
    else $error("segments lit with no grid");
  // reset leaves every output quiet, checked on the edge after reset is sampled low
  reset_lines_a: assert property (disable iff (1'b0) !NRST |=>
    (GRID_LINES == 11'h000 && SEGMENT_LINES == 16'h0000 && !RDATA_VALID && !GPR_SEL))
    else $error("outputs active after reset");

  last_grid_c: cover property (GRID_LINES[10]);
  dmem_write_c: cover property (dmem_we ##[1:300] SEGMENT_LINES != 16'h0000);
  halt_c: cover property (disp_q == DISP_RUN ##1 disp_q == DISP_HALT);
  wide_pulse_c: cover property (ctrl_q[DIM_LSB +: 3] == 3'h7 && GRID_LINES != 11'h000);
  rtc_halt_c: cover property (HALT && OPT_RTC_SRC && GRID_LINES != 11'h000);

endmodule

// >>> logic/vfd_pkg.sv
package vfd_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [7:0] BANK_PTR_ADDR = 8'h04;  // ram bank select pointer
  localparam logic [7:0] CTRL_ADDR     = 8'h28;  // display_control
  localparam logic [7:0] DMEM_FIRST    = 8'h40;  // first display byte
  localparam logic [7:0] DMEM_LAST     = 8'h55;  // last display byte
  localparam logic [7:0] DMEM_BANK     = 8'h01;  // bank holding the display bytes

  // ****************************************
  // display_control layout and resets
  // ****************************************
  localparam int         ARR_LSB    = 0;       // grid_segment_arrangement 2..0
  localparam int         UNUSED_BIT = 3;       // reads as zero
  localparam int         ENABLE_BIT = 4;       // display_drive_enable
  localparam int         DIM_LSB    = 5;       // dimming_pulse_width 7..5
  localparam logic [7:0] CTRL_WMASK = 8'hF7;   // keeps the unused bit clear
  localparam logic [7:0] CTRL_RESET = 8'h07;   // 11 grids, 1/16, disabled
  localparam logic [7:0] BANK_RESET = 8'h00;

  // ****************************************
  // scan geometry and clocking
  // ****************************************
  localparam int         GRIDS      = 11;      // grid_lines
  localparam int         SEGS       = 16;      // segment_lines
  localparam logic [3:0] LAST_PHASE = 4'hF;    // sixteen phases per grid slot
  localparam logic [1:0] SYS_DIV_LAST = 2'h3;  // system clock divided by 4

  typedef enum logic [2:0] {
    DISP_OFF  = 3'b001,
    DISP_RUN  = 3'b010,
    DISP_HALT = 3'b100
  } disp_state_e;

  // grids in use for an arrangement code: 4..11
  function automatic logic [3:0] grid_count(input logic [2:0] arr);
    grid_count = 4'(arr) + 4'h4;
  endfunction

  // mask of segments in use: 16 for codes 0..2, then 15 down to 11
  function automatic logic [15:0] seg_mask(input logic [2:0] arr);
    seg_mask = (arr <= 3'h2) ? 16'hFFFF : (16'hFFFF >> (arr - 3'h2));
  endfunction

  // on-time in sixteenths for a dimming code
  function automatic logic [4:0] dim_width(input logic [2:0] code);
    case (code)
      3'h0:    dim_width = 5'h01;
      3'h1:    dim_width = 5'h02;
      3'h2:    dim_width = 5'h04;
      3'h3:    dim_width = 5'h0A;
      3'h4:    dim_width = 5'h0B;
      3'h5:    dim_width = 5'h0C;
      3'h6:    dim_width = 5'h0D;
      default: dim_width = 5'h0E;
    endcase
  endfunction

endpackage

// >>> logic/vfd_dmem.sv
`timescale 1ns/1ps
// display memory: 11 grid words, each two bytes, cpu and scan ports
module vfd_dmem
  import vfd_pkg::*;
(
  // clock
  input  wire logic        clk,
  // cpu byte port
  input  wire logic        cpu_we,
  input  wire logic [4:0]  cpu_idx,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // scan word port
  input  wire logic [3:0]  scan_grid,
  output logic      [15:0] scan_word
);

  logic [7:0] lo_mem [0:GRIDS-1];  // even bytes, segments 7..0
  logic [7:0] hi_mem [0:GRIDS-1];  // odd bytes, segments 15..8

  // contents survive any display disable; no reset on the array
  always_ff @(posedge clk) begin
    if (cpu_we && !cpu_idx[0]) begin
      lo_mem[cpu_idx[4:1]] <= cpu_wdata;
    end
    if (cpu_we && cpu_idx[0]) begin
      hi_mem[cpu_idx[4:1]] <= cpu_wdata;
    end
    cpu_rdata <= cpu_idx[0] ? hi_mem[cpu_idx[4:1]] : lo_mem[cpu_idx[4:1]];
    scan_word <= {hi_mem[scan_grid], lo_mem[scan_grid]};
  end

endmodule

// >>> logic/vfd_tick.sv
`timescale 1ns/1ps
// driver clock: rtc edge or system/4, then divided by 2^0..2^7
module vfd_tick
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // option straps
  input  wire logic       rtc_src,
  input  wire logic [2:0] div_sel,
  input  wire logic       rtc_osc,
  // one-cycle driver tick
  output logic            tick
);

  logic [1:0] pre_q, pre_d;    // system clock /4 prescaler
  logic       rtc_q, rtc_d;    // last rtc level for edge detect
  logic [6:0] div_q, div_d;    // power-of-two divider
  logic       tick_q, tick_d;
  logic       src_tick;
  logic [6:0] mask;

  // source pick then divider; tick fires when the masked bits are all ones
  always_comb begin
    pre_d    = pre_q + 2'h1;
    rtc_d    = rtc_osc;
    src_tick = rtc_src ? (rtc_osc && !rtc_q) : (pre_q == SYS_DIV_LAST);
    mask     = 7'(8'hFF >> (4'h8 - {1'b0, div_sel}));
    div_d    = src_tick ? div_q + 7'h01 : div_q;
    tick_d   = src_tick && ((div_q & mask) == mask);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q  <= 2'h0;
      rtc_q  <= 1'b0;
      div_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      rtc_q  <= rtc_d;
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// >>> testbench/vfd_tube_model.sv
`timescale 1ns/1ps
// tube stand-in: times each grid pulse and follows the scan order
module vfd_tube_model (
  // clock and order clear
  input  wire logic        clk,
  input  wire logic        clr,
  // tube drive
  input  wire logic [10:0] grid,
  input  wire logic [15:0] seg,
  // measurements
  output logic      [15:0] w_last,
  output logic      [15:0] s_last,
  output logic      [3:0]  g_last,
  output logic      [3:0]  grids,
  output logic             seen,
  output int               ord_err
);
  logic [15:0] cnt = 16'h0;  // cycles of the running pulse
  logic        on = 1'b0;    // a grid is lit
  logic        ok = 1'b0;    // last grid known
  logic [3:0]  idx;          // grid now lit

  // ****************************************
  // pulse timing and scan order
  // ****************************************
  // the tube cannot answer back, so faults are only counted here
  always @(posedge clk) begin
    seen <= 1'b0;
    if (clr) begin
      ok <= 1'b0;
    end
    idx = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (grid[i]) idx = 4'(i);
    end
    if (grid != 11'h000) begin
      if (!$onehot(grid)) ord_err <= ord_err + 1;
      if (!on) begin
        // next grid in turn, or a wrap to grid 0
        if (ok && idx != g_last + 4'h1 && idx != 4'h0) ord_err <= ord_err + 1;
        if (ok && idx == 4'h0) grids <= g_last + 4'h1;
        g_last <= idx;
        ok     <= 1'b1;
      end
      on     <= 1'b1;
      cnt    <= cnt + 16'h1;
      s_last <= seg;
    end else begin
      // segments must stay dark between pulses
      if (seg != 16'h0) ord_err <= ord_err + 1;
      if (on) begin
        w_last <= cnt;
        seen   <= 1'b1;
      end
      on  <= 1'b0;
      cnt <= 16'h0;
    end
  end
endmodule

// >>> testbench/vfd_display_driver_bench.sv
`timescale 1ns/1ps
module vfd_display_driver_bench
  import vfd_pkg::*;
;
  logic        MCLK = 1'b0, NRST = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0, INDIRECT = 1'b0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic        RDATA_VALID, GPR_SEL, HALT = 1'b0, RTC_OSC = 1'b0, CLR = 1'b0;
  logic        OPT_RTC_SRC = 1'b0, OPT_HALT_ON = 1'b1;
  logic [2:0]  OPT_DIV_SEL = 3'h0;
  logic [10:0] GRID_LINES;
  logic [15:0] SEGMENT_LINES, w_last, s_last;
  logic [3:0]  g_last, grids;
  logic        seen;
  int          ord_err, failures = 0, checks = 0, ncyc = 0;
  logic [15:0] q[$];                      // expected read answers
  logic [7:0]  mem [22];                  // display bytes written
  logic [7:0]  bk [4] = '{8'h00, 8'h02, 8'h03, 8'h04};
  logic [4:0]  wt [8] = '{5'h01, 5'h02, 5'h04, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E};

  // ****************************************
  // clock, rtc source, instances
  // ****************************************
  always #10 MCLK = ~MCLK;
  // rtc rises every 10 system cycles, off phase with the bus
  always begin
    repeat (5) @(posedge MCLK);
    #1 RTC_OSC = ~RTC_OSC;
  end
  vfd_display_driver i_vfd_display_driver (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .INDIRECT(INDIRECT), .WDATA(WDATA), .RDATA(RDATA),
    .RDATA_VALID(RDATA_VALID), .GPR_SEL(GPR_SEL), .OPT_RTC_SRC(OPT_RTC_SRC),
    .OPT_DIV_SEL(OPT_DIV_SEL), .OPT_HALT_ON(OPT_HALT_ON), .RTC_OSC(RTC_OSC), .HALT(HALT),
    .GRID_LINES(GRID_LINES), .SEGMENT_LINES(SEGMENT_LINES));
  vfd_tube_model i_vfd_tube_model (.clk(MCLK), .clr(CLR), .grid(GRID_LINES),
    .seg(SEGMENT_LINES), .w_last(w_last), .s_last(s_last), .g_last(g_last),
    .grids(grids), .seen(seen), .ord_err(ord_err));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // each read answer is matched to the oldest note
  always @(posedge MCLK) begin
    if (RDATA_VALID === 1'b1) begin
      chk({8'h00, RDATA}, (q.size() > 0) ? q.pop_front() : 16'hFFFF);
    end
  end
  // a hang ends the run well past the longest expected length
  always @(posedge MCLK) begin
    ncyc++;
    if (ncyc == 60000) begin
      failures++;
      stop_test();
    end
  end

  // ****************************************
  // bus and tube tasks
  // ****************************************
  task automatic cyc;
    @(posedge MCLK);
    #1;
  endtask
  // an idle edge first, so strobes never drop and rise in one step
  task automatic acc(input logic [7:0] a, input logic w, input logic ind, input logic [7:0] d);
    cyc();
    ADDR     = a;
    WR_EN    = w;
    RD_EN    = !w;
    INDIRECT = ind;
    WDATA    = d;
    cyc();
    WR_EN = 1'b0;
    RD_EN = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic ind, input logic [7:0] e);
    q.push_back({8'h00, e});
    acc(a, 1'b0, ind, 8'h00);
  endtask
  task automatic gpr(input logic [7:0] a, input logic w, input logic ind, input logic [7:0] d);
    acc(a, w, ind, d);
    chk({15'h0, GPR_SEL}, 16'h1);
  endtask
  task automatic wait_grid(input logic [3:0] g);
    for (int n = 0; n < 5000 && !(seen === 1'b1 && g_last === g); n++) cyc();
  endtask
  function automatic logic [15:0] mask(input logic [2:0] a);
    return (a <= 3'h2) ? 16'hFFFF : 16'hFFFF >> (a - 3'h2);
  endfunction
  // one tube set-up: drive off, clear order, then drive as asked
  task automatic run(input logic [2:0] arr, input logic [2:0] dim, input logic div,
                     input logic rtc, input logic hon, input logic hlt, input logic en,
                     input logic on);
    int          lit;
    logic [15:0] p;
    OPT_RTC_SRC = rtc;
    OPT_DIV_SEL = {2'b00, div};
    OPT_HALT_ON = hon;
    HALT        = hlt;
    acc(CTRL_ADDR, 1'b1, 1'b0, {dim, 2'b00, arr});
    repeat (3) cyc();
    CLR = 1'b1;
    cyc();
    CLR = 1'b0;
    acc(CTRL_ADDR, 1'b1, 1'b0, {dim, en, 1'b0, arr});
    if (on) begin
      p = (rtc ? 16'd10 : 16'd4) << div;
      wait_grid(4'h1);
      chk(w_last, 16'(wt[dim]) * p);
      chk(s_last, {mem[3], mem[2]} & mask(arr));
      wait_grid(4'h0);
      chk({12'h0, grids}, 16'(arr) + 16'h4);
    end else begin
      lit = 0;
      repeat (3) cyc();
      repeat (400) begin
        cyc();
        if (GRID_LINES !== 11'h0 || SEGMENT_LINES !== 16'h0) lit++;
      end
      chk(16'(lit), 16'h0);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] r;
    void'($urandom(32'hD6B5FD65));
    repeat (5) @(posedge MCLK);
    #1;
    NRST = 1'b1;
    rd(CTRL_ADDR, 1'b0, CTRL_RESET);
    r = 8'($urandom) | 8'h08;
    acc(CTRL_ADDR, 1'b1, 1'b0, r);
    rd(CTRL_ADDR, 1'b0, r & CTRL_WMASK);
    acc(BANK_PTR_ADDR, 1'b1, 1'b0, DMEM_BANK);
    rd(BANK_PTR_ADDR, 1'b0, DMEM_BANK);
    for (int i = 0; i < 22; i++) begin
      mem[i] = 8'($urandom);
      acc(DMEM_FIRST + 8'(i), 1'b1, 1'b1, mem[i]);
    end
    for (int i = 0; i < 22; i++) rd(DMEM_FIRST + 8'(i), 1'b1, mem[i]);
    gpr(DMEM_FIRST, 1'b0, 1'b0, 8'h00);
    // a direct write in bank one must not touch the display byte
    gpr(DMEM_FIRST, 1'b1, 1'b0, ~mem[0]);
    rd(DMEM_FIRST, 1'b1, mem[0]);
    // other banks must leave the display bytes alone
    for (int b = 0; b < 4; b++) begin
      acc(BANK_PTR_ADDR, 1'b1, 1'b0, bk[b]);
      gpr(DMEM_FIRST, 1'b1, 1'b1, ~mem[0]);
      acc(BANK_PTR_ADDR, 1'b1, 1'b0, DMEM_BANK);
      rd(DMEM_FIRST, 1'b1, mem[0]);
    end
    for (int k = 0; k < 8; k++) begin
      run(3'(k), 3'(7 - k), k == 2, k >= 5, 1'b1, k == 6, 1'b1, 1'b1);
    end
    run(3'h7, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    run(3'h7, 3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    run(3'h7, 3'h7, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(DMEM_FIRST, 1'b1, mem[0]);
    repeat (4) cyc();
    // a second reset in mid-run: control back to reset value, bytes kept
    NRST = 1'b0;
    repeat (2) cyc();
    NRST = 1'b1;
    rd(CTRL_ADDR, 1'b0, CTRL_RESET);
    acc(BANK_PTR_ADDR, 1'b1, 1'b0, DMEM_BANK);
    rd(DMEM_LAST, 1'b1, mem[21]);
    repeat (4) cyc();
    chk(16'(q.size()), 16'h0);
    chk(16'(ord_err), 16'h0);
    stop_test();
  end
endmodule
